/* File: thermal_bank_defines.svh */
/*
 * Register bank constants: command bytes, reset values and control
 * register field positions of the three-zone thermal supervisor.
 * Assumes it is included by bare name and holds definitions only.
 */
`ifndef THERMAL_BANK_DEFINES_SVH
`define THERMAL_BANK_DEFINES_SVH

// command bytes
`define CMD_LOCAL_RESULT     8'h00
`define CMD_CONTROL          8'h01
`define CMD_LOCAL_HYST       8'h02
`define CMD_LOCAL_SET        8'h03
`define CMD_ONE_RESULT       8'h10
`define CMD_ONE_HYST         8'h12
`define CMD_ONE_SET          8'h13
`define CMD_TWO_RESULT       8'h20
`define CMD_TWO_HYST         8'h22
`define CMD_TWO_SET          8'h23

// power-up values
`define RST_CONTROL          8'h00
`define RST_RESULT           8'h00
`define RST_LOCAL_HYST       8'h4C
`define RST_LOCAL_SET        8'h51
`define RST_REMOTE_HYST      8'h5C
`define RST_REMOTE_SET       8'h61
`define RST_UNMAPPED         8'h00

// control register fields
`define BIT_LOCAL_EVENT      7
`define BIT_REMOTE_EVENT     6
`define BIT_REMOTE_OVERTEMP  5
`define FQ_HI                4
`define FQ_LO                3
`define BIT_ALERT_MASK       2
`define BIT_ALERT_MODE       1
`define BIT_SHUTDOWN         0

`endif

/* File: thermal_pkg.sv */
/*
 * Types and shared arithmetic of the thermal register bank.
 * Assumes nothing of its surroundings.
 */
package thermal_pkg;

    // alert state in interrupt mode
    typedef enum logic {ALERT_IDLE, ALERT_ACTIVE} alert_state_t;

    // two's complement, one degree per lsb
    typedef logic [7:0] temp_t;

    // fault queue depth code to number of conversions
    function automatic logic [2:0] queue_depth(input logic [1:0] code);
        case (code)
            2'h0:    queue_depth = 3'h1;
            2'h1:    queue_depth = 3'h2;
            2'h2:    queue_depth = 3'h4;
            default: queue_depth = 3'h6;
        endcase
    endfunction : queue_depth

endpackage : thermal_pkg

/* File: zone_fault_queue.sv */
/*
 * Per-zone fault queue: counts consecutive conversions holding an
 * over- or under-temperature condition and toggles the zone state.
 * Assumes conv_done is a one-cycle strobe with temp already valid.
 */
`timescale 1ns/1ps
module zone_fault_queue (
    input  wire logic              ref_clk,
    input  wire logic              arst_n,
    input  wire logic              clk_en,
    input  wire logic              conv_done,
    input  wire logic              clear,
    input  wire thermal_pkg::temp_t temp,
    input  wire thermal_pkg::temp_t setpoint,
    input  wire thermal_pkg::temp_t hysteresis,
    input  wire logic [1:0]        depth_sel,
    output logic                   event_pulse,
    output logic                   over_state
);
    logic [2:0] count;
    logic [1:0] depth_seen;

    // signed compares; in over state only the low side is watched
    wire       above      = $signed(temp) > $signed(setpoint);
    wire       below      = $signed(temp) < $signed(hysteresis);
    wire       cond       = over_state ? below : above;
    wire [2:0] depth      = thermal_pkg::queue_depth(depth_sel);
    // a depth change restarts the count, so a shallower queue never
    // inherits a count that is already past its new depth
    wire       restart    = depth_sel != depth_seen;
    wire [2:0] base       = restart ? 3'h0 : count;
    wire [2:0] next_count = cond ? 3'(base + 3'h1) : 3'h0;
    wire       hit        = cond && (next_count >= depth);

    // consecutive count
    // counter stays below depth except just after a depth change, and never passes 5, so 3 bits cannot wrap
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            count       <= 3'h0;
            over_state  <= 1'b0;
            event_pulse <= 1'b0;
            depth_seen  <= 2'h0;
        end
        else if (clk_en)
        begin
            event_pulse <= 1'b0;
            depth_seen  <= depth_sel;
            if (clear)
            begin
                count      <= 3'h0;
                over_state <= 1'b0;
            end
            else if (conv_done)
            begin
                count       <= hit ? 3'h0 : next_count;
                over_state  <= hit ? ~over_state : over_state;
                event_pulse <= hit;
            end
            else if (restart)
                count <= 3'h0;
        end
    end

    a_event_on_hit: assert property (@(posedge ref_clk)
        disable iff (!arst_n) clk_en && conv_done && !clear && hit
        |=> event_pulse)
        else $error("qualified condition gave no event");

    a_event_cause: assert property (@(posedge ref_clk)
        disable iff (!arst_n)
        $rose(event_pulse) |-> $past(conv_done) && $past(cond))
        else $error("event without a qualifying conversion");

    a_depth_bound: assert property (@(posedge ref_clk)
        disable iff (!arst_n) !restart |-> count < depth)
        else $error("fault queue count reached depth");

endmodule : zone_fault_queue

/* File: three_zone_thermal_register_bank.sv */
/*
 * Command-byte addressed register bank of a three-zone thermal
 * supervisor: results, limits, control/status and alert pin.
 * Assumes a serial bus engine presents cmd_byte with one-cycle
 * read and write strobes, and a conversion engine pulses conv_done
 * with the three zone temperatures valid in that cycle.
 */
// Function
// - local result 0x00, hysteresis 0x02, setpoint 0x03, 8 bits
// - zone one result 0x10, hysteresis 0x12, setpoint 0x13
// - zone two result 0x20, hysteresis 0x22, setpoint 0x23
// - control register at 0x01, all zeros at power-up
// - limits reset to 0x4C/0x51 local, 0x5C/0x61 remote
// - results read zero until their first conversion completes
// - after fault-queue conversions, overtemp zones set status
// - bit 7 local event flag, bit 6 remote event flag
// - bit 5 remote overtemperature present, read only
// - bits 4:3 fault queue depth 1,2,4,6; default one
// - bit 1 alert mode: one interrupt, zero comparator
// - bit 0 shutdown select, normal after reset
// - all temperatures are 8-bit two's complement degrees
// - no events pending after power-up
// - in interrupt mode any register read releases alert
// - event flags clear by reading control register or on shutdown entry
// - entering shutdown releases alert, clears event flags
// - events need fault-queue consecutive conversions per zone
`timescale 1ns/1ps
`include "thermal_bank_defines.svh"
module three_zone_thermal_register_bank (
    input  wire logic              ref_clk,
    input  wire logic              arst_n,
    input  wire logic              clk_en,
    input  wire logic [7:0]        cmd_byte,
    input  wire logic              wr_strobe,
    input  wire logic [7:0]        wr_data,
    input  wire logic              rd_strobe,
    output logic [7:0]             rd_data,
    input  wire logic              conv_done,
    input  wire thermal_pkg::temp_t local_conv_temp,
    input  wire thermal_pkg::temp_t zone_one_conv_temp,
    input  wire thermal_pkg::temp_t zone_two_conv_temp,
    output logic                   shutdown_active,
    output logic                   alert_out,
    output logic                   alert_oe_n
);
    // all temperature storage is two's complement bytes
    thermal_pkg::temp_t local_temp_result;
    thermal_pkg::temp_t zone_one_temp_result;
    thermal_pkg::temp_t zone_two_temp_result;
    thermal_pkg::temp_t local_hysteresis_limit;
    thermal_pkg::temp_t local_setpoint_limit;
    thermal_pkg::temp_t zone_one_hysteresis_limit;
    thermal_pkg::temp_t zone_one_setpoint_limit;
    thermal_pkg::temp_t zone_two_hysteresis_limit;
    thermal_pkg::temp_t zone_two_setpoint_limit;

    logic                      local_event_flag;
    logic                      remote_event_flag;
    logic [1:0]                fault_queue_depth;
    logic                      alert_mask;
    logic                      alert_mode;
    logic                      shutdown_select;
    thermal_pkg::alert_state_t alert_state;
    thermal_pkg::alert_state_t next_alert_state;

    logic local_evt;
    logic one_evt;
    logic two_evt;
    logic local_over;
    logic one_over;
    logic two_over;

    // power-up control image; a literal cannot be part-selected directly
    localparam logic [7:0] control_power_up = `RST_CONTROL;

    wire wr_ctrl     = wr_strobe && (cmd_byte == `CMD_CONTROL);
    wire wr_lhyst    = wr_strobe && (cmd_byte == `CMD_LOCAL_HYST);
    wire wr_lset     = wr_strobe && (cmd_byte == `CMD_LOCAL_SET);
    wire wr_one_hyst = wr_strobe && (cmd_byte == `CMD_ONE_HYST);
    wire wr_one_set  = wr_strobe && (cmd_byte == `CMD_ONE_SET);
    wire wr_two_hyst = wr_strobe && (cmd_byte == `CMD_TWO_HYST);
    wire wr_two_set  = wr_strobe && (cmd_byte == `CMD_TWO_SET);
    wire rd_ctrl     = rd_strobe && (cmd_byte == `CMD_CONTROL);

    // conversions halt in shutdown, so stale strobes are dropped
    wire conv_live      = conv_done && !shutdown_select;
    // shutdown entry detected on the write itself
    wire shutdown_enter = wr_ctrl && wr_data[`BIT_SHUTDOWN]
                          && !shutdown_select;
    wire any_event      = local_evt || one_evt || two_evt;
    wire any_over       = local_over || one_over || two_over;
    // level of remote overtemperature, not sticky
    wire remote_overtemp_flag = one_over || two_over;

    wire [7:0] control_image = {local_event_flag, remote_event_flag,
                                remote_overtemp_flag, fault_queue_depth,
                                alert_mask, alert_mode, shutdown_select};

    // read mux; unmapped command bytes read zero
    wire [7:0] read_mux =
        (cmd_byte == `CMD_LOCAL_RESULT) ? local_temp_result         :
        (cmd_byte == `CMD_CONTROL)      ? control_image             :
        (cmd_byte == `CMD_LOCAL_HYST)   ? local_hysteresis_limit    :
        (cmd_byte == `CMD_LOCAL_SET)    ? local_setpoint_limit      :
        (cmd_byte == `CMD_ONE_RESULT)   ? zone_one_temp_result      :
        (cmd_byte == `CMD_ONE_HYST)     ? zone_one_hysteresis_limit :
        (cmd_byte == `CMD_ONE_SET)      ? zone_one_setpoint_limit   :
        (cmd_byte == `CMD_TWO_RESULT)   ? zone_two_temp_result      :
        (cmd_byte == `CMD_TWO_HYST)     ? zone_two_hysteresis_limit :
        (cmd_byte == `CMD_TWO_SET)      ? zone_two_setpoint_limit   :
                                          `RST_UNMAPPED;

    // set wins over read clear; shutdown clears all
    wire next_local_flag  = shutdown_enter ? 1'b0 :
                            (local_evt || (local_event_flag && !rd_ctrl));
    wire next_remote_flag = shutdown_enter ? 1'b0 :
                            (one_evt || two_evt
                             || (remote_event_flag && !rd_ctrl));

    // per-zone fault queues, cleared on shutdown entry
    zone_fault_queue u_local_queue (
        .ref_clk     (ref_clk),
        .arst_n      (arst_n),
        .clk_en      (clk_en),
        .conv_done   (conv_live),
        .clear       (shutdown_enter),
        .temp        (local_conv_temp),
        .setpoint    (local_setpoint_limit),
        .hysteresis  (local_hysteresis_limit),
        .depth_sel   (fault_queue_depth),
        .event_pulse (local_evt),
        .over_state  (local_over)
    );

    zone_fault_queue u_one_queue (
        .ref_clk     (ref_clk),
        .arst_n      (arst_n),
        .clk_en      (clk_en),
        .conv_done   (conv_live),
        .clear       (shutdown_enter),
        .temp        (zone_one_conv_temp),
        .setpoint    (zone_one_setpoint_limit),
        .hysteresis  (zone_one_hysteresis_limit),
        .depth_sel   (fault_queue_depth),
        .event_pulse (one_evt),
        .over_state  (one_over)
    );

    zone_fault_queue u_two_queue (
        .ref_clk     (ref_clk),
        .arst_n      (arst_n),
        .clk_en      (clk_en),
        .conv_done   (conv_live),
        .clear       (shutdown_enter),
        .temp        (zone_two_conv_temp),
        .setpoint    (zone_two_setpoint_limit),
        .hysteresis  (zone_two_hysteresis_limit),
        .depth_sel   (fault_queue_depth),
        .event_pulse (two_evt),
        .over_state  (two_over)
    );

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            local_temp_result    <= `RST_RESULT;
            zone_one_temp_result <= `RST_RESULT;
            zone_two_temp_result <= `RST_RESULT;
        end
        else if (clk_en && conv_live)
        begin
            local_temp_result    <= local_conv_temp;
            zone_one_temp_result <= zone_one_conv_temp;
            zone_two_temp_result <= zone_two_conv_temp;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            local_hysteresis_limit    <= `RST_LOCAL_HYST;
            local_setpoint_limit      <= `RST_LOCAL_SET;
            zone_one_hysteresis_limit <= `RST_REMOTE_HYST;
            zone_one_setpoint_limit   <= `RST_REMOTE_SET;
            zone_two_hysteresis_limit <= `RST_REMOTE_HYST;
            zone_two_setpoint_limit   <= `RST_REMOTE_SET;
        end
        else if (clk_en)
        begin
            if (wr_lhyst)    local_hysteresis_limit    <= wr_data;
            if (wr_lset)     local_setpoint_limit      <= wr_data;
            if (wr_one_hyst) zone_one_hysteresis_limit <= wr_data;
            if (wr_one_set)  zone_one_setpoint_limit   <= wr_data;
            if (wr_two_hyst) zone_two_hysteresis_limit <= wr_data;
            if (wr_two_set)  zone_two_setpoint_limit   <= wr_data;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            fault_queue_depth <= control_power_up[`FQ_HI:`FQ_LO];
            alert_mask        <= control_power_up[`BIT_ALERT_MASK];
            alert_mode        <= control_power_up[`BIT_ALERT_MODE];
            shutdown_select   <= control_power_up[`BIT_SHUTDOWN];
        end
        else if (clk_en && wr_ctrl)
        begin
            fault_queue_depth <= wr_data[`FQ_HI:`FQ_LO];
            alert_mask        <= wr_data[`BIT_ALERT_MASK];
            alert_mode        <= wr_data[`BIT_ALERT_MODE];
            shutdown_select   <= wr_data[`BIT_SHUTDOWN];
        end
    end

    // sticky flags, reset clear, never host written
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            local_event_flag  <= 1'b0;
            remote_event_flag <= 1'b0;
        end
        else if (clk_en)
        begin
            local_event_flag  <= next_local_flag;
            remote_event_flag <= next_remote_flag;
        end
    end

    // read data captured on the strobe, before the flag clear lands
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            rd_data <= `RST_UNMAPPED;
        else if (clk_en && rd_strobe)
            rd_data <= read_mux;
    end

    // interrupt-mode latch; an event beats a read
    always_comb
    begin
        next_alert_state = alert_state;
        case (alert_state)
            thermal_pkg::ALERT_IDLE:
                if (any_event && alert_mode)
                    next_alert_state = thermal_pkg::ALERT_ACTIVE;
            thermal_pkg::ALERT_ACTIVE:
                if (rd_strobe && !any_event)
                    next_alert_state = thermal_pkg::ALERT_IDLE;
            default:
                next_alert_state = thermal_pkg::ALERT_IDLE;
        endcase
        if (shutdown_enter || !alert_mode)
            next_alert_state = thermal_pkg::ALERT_IDLE;
    end

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            alert_state <= thermal_pkg::ALERT_IDLE;
        else if (clk_en)
            alert_state <= next_alert_state;
    end

    // mask gates the pin in both modes
    // open drain: line is only ever pulled low, never driven high
    wire alert_assert = !alert_mask
        && (alert_mode ? (alert_state == thermal_pkg::ALERT_ACTIVE)
                       : any_over);
    assign alert_out       = 1'b0;
    assign alert_oe_n      = !alert_assert;
    assign shutdown_active = shutdown_select;

    a_result_readonly: assert property (@(posedge ref_clk)
        disable iff (!arst_n) clk_en && wr_strobe && !conv_live
        |=> $stable(local_temp_result) && $stable(zone_one_temp_result)
            && $stable(zone_two_temp_result))
        else $error("result register changed without a conversion");

    a_result_loads: assert property (@(posedge ref_clk)
        disable iff (!arst_n) clk_en && conv_live
        |=> zone_two_temp_result == $past(zone_two_conv_temp))
        else $error("result did not take the conversion value");

    a_flag_set_wins: assert property (@(posedge ref_clk)
        disable iff (!arst_n) clk_en && local_evt && !shutdown_enter
        |=> local_event_flag)
        else $error("local event did not set its flag");

    a_flag_read_clear: assert property (@(posedge ref_clk)
        disable iff (!arst_n) clk_en && rd_ctrl && !one_evt && !two_evt
        |=> !remote_event_flag)
        else $error("control read did not clear remote flag");

    a_flag_sticky: assert property (@(posedge ref_clk)
        disable iff (!arst_n) clk_en && local_event_flag && !rd_ctrl
        && !shutdown_enter |=> local_event_flag)
        else $error("local flag cleared without a control read");

    a_shutdown_clears: assert property (@(posedge ref_clk)
        disable iff (!arst_n) clk_en && shutdown_enter
        |=> !local_event_flag && !remote_event_flag && alert_oe_n
            && !remote_overtemp_flag)
        else $error("shutdown entry left flags or alert set");

    a_read_releases: assert property (@(posedge ref_clk)
        disable iff (!arst_n) clk_en && alert_mode && rd_strobe
        && !any_event && !wr_ctrl |=> alert_oe_n)
        else $error("read did not release alert in interrupt mode");

    a_mask_blocks: assert property (@(posedge ref_clk)
        disable iff (!arst_n) alert_mask |-> alert_oe_n)
        else $error("masked alert pulled the pin");

    a_ctrl_readback: assert property (@(posedge ref_clk)
        disable iff (!arst_n) clk_en && rd_ctrl
        |=> rd_data[4:0] == $past(control_image[4:0]))
        else $error("control read returned wrong low bits");

endmodule : three_zone_thermal_register_bank

/* File: thermal_host_model.sv */
/*
 * Host-side model of the register bus: single-byte writes and reads.
 * Assumes the bank takes a strobe on the rising edge it is seen high.
 */
`timescale 1ns/1ps
module thermal_host_model (
    input  wire logic       ref_clk,
    input  wire logic [7:0] rd_data,
    output logic [7:0]      cmd_byte,
    output logic            wr_strobe,
    output logic [7:0]      wr_data,
    output logic            rd_strobe
);
    // quiet bus before the first transfer
    initial
    begin
        cmd_byte  = 8'h00;
        wr_strobe = 1'b0;
        wr_data   = 8'h00;
        rd_strobe = 1'b0;
    end

    // released lines show the inverse so stale values never pass
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        cmd_byte  <= a;
        wr_data   <= d;
        wr_strobe <= 1'b1;
        @(posedge ref_clk);
        wr_strobe <= 1'b0;
        cmd_byte  <= ~a;
        wr_data   <= ~d;
    endtask : write_reg

    // read data is registered on the taking edge
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        cmd_byte  <= a;
        rd_strobe <= 1'b1;
        @(posedge ref_clk);
        rd_strobe <= 1'b0;
        cmd_byte  <= ~a;
        #1;
        d = rd_data;
    endtask : read_reg
endmodule : thermal_host_model

/* File: three_zone_thermal_register_bank_tb.sv */
/*
 * Self-checking bench of the thermal register bank: table of register
 * accesses, then conversions, alert modes, shutdown and reset.
 * Assumes the host model drives the bus; clk_en stays high except for the final write.
 */
`timescale 1ns/1ps
module three_zone_thermal_register_bank_tb;
    typedef struct packed {
        logic [7:0] a;
        logic       w;
        logic [7:0] d;
        logic [7:0] e;
    } row_t;

    logic               ref_clk = 1'b0;
    logic               arst_n = 1'b0;
    logic               clk_en = 1'b1;
    logic [7:0]         cmd_byte;
    logic               wr_strobe;
    logic [7:0]         wr_data;
    logic               rd_strobe;
    logic [7:0]         rd_data;
    logic               conv_done = 1'b0;
    thermal_pkg::temp_t local_conv_temp = 8'h00;
    thermal_pkg::temp_t zone_one_conv_temp = 8'h00;
    thermal_pkg::temp_t zone_two_conv_temp = 8'h00;
    logic               shutdown_active;
    logic               alert_out;
    logic               alert_oe_n;
    int                 num_errors = 0;
    int                 num_checks = 0;
    logic [7:0]         rd_val;
    row_t               row;

    // address, write enable, write data, expected read
    row_t rows [23] = '{
        '{8'h00, 1'b0, 8'h00, 8'h00}, '{8'h01, 1'b0, 8'h00, 8'h00},
        '{8'h02, 1'b0, 8'h00, 8'h4C}, '{8'h03, 1'b0, 8'h00, 8'h51},
        '{8'h10, 1'b0, 8'h00, 8'h00}, '{8'h12, 1'b0, 8'h00, 8'h5C},
        '{8'h13, 1'b0, 8'h00, 8'h61}, '{8'h20, 1'b0, 8'h00, 8'h00},
        '{8'h22, 1'b0, 8'h00, 8'h5C}, '{8'h23, 1'b0, 8'h00, 8'h61},
        '{8'h05, 1'b0, 8'h00, 8'h00}, '{8'h02, 1'b1, 8'h10, 8'h10},
        '{8'h03, 1'b1, 8'h20, 8'h20}, '{8'h12, 1'b1, 8'h18, 8'h18},
        '{8'h13, 1'b1, 8'h30, 8'h30}, '{8'h22, 1'b1, 8'h28, 8'h28},
        '{8'h23, 1'b1, 8'h40, 8'h40}, '{8'h00, 1'b1, 8'h77, 8'h00},
        '{8'h10, 1'b1, 8'h77, 8'h00}, '{8'h20, 1'b1, 8'h77, 8'h00},
        '{8'h05, 1'b1, 8'h33, 8'h00}, '{8'h01, 1'b1, 8'hFF, 8'h1F},
        '{8'h01, 1'b1, 8'h00, 8'h00}};

    // device under test and host on its bus
    three_zone_thermal_register_bank dut_u (
        .ref_clk(ref_clk), .arst_n(arst_n), .clk_en(clk_en),
        .cmd_byte(cmd_byte), .wr_strobe(wr_strobe), .wr_data(wr_data),
        .rd_strobe(rd_strobe), .rd_data(rd_data), .conv_done(conv_done),
        .local_conv_temp(local_conv_temp),
        .zone_one_conv_temp(zone_one_conv_temp),
        .zone_two_conv_temp(zone_two_conv_temp),
        .shutdown_active(shutdown_active), .alert_out(alert_out),
        .alert_oe_n(alert_oe_n));
    thermal_host_model host_u (
        .ref_clk(ref_clk), .rd_data(rd_data), .cmd_byte(cmd_byte),
        .wr_strobe(wr_strobe), .wr_data(wr_data), .rd_strobe(rd_strobe));

    // 20 MHz clock
    always #25 ref_clk = ~ref_clk;

    task automatic chk8(input logic [7:0] g, input logic [7:0] e);
        num_checks++;
        if (g !== e)
        begin
            num_errors++;
            $display("[FAIL] %0t got %h expected %h", $time, g, e);
        end
    endtask : chk8

    task automatic chk1(input logic g, input logic e);
        chk8({7'h00, g}, {7'h00, e});
    endtask : chk1

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        host_u.read_reg(a, rd_val);
        chk8(rd_val, e);
    endtask : rd_chk

    // flag and interrupt settle one edge after the taking edge
    task automatic conv(input logic [7:0] l, o, t);
        @(posedge ref_clk);
        local_conv_temp    <= l;
        zone_one_conv_temp <= o;
        zone_two_conv_temp <= t;
        conv_done          <= 1'b1;
        @(posedge ref_clk);
        conv_done <= 1'b0;
        repeat (2) @(posedge ref_clk);
        #1;
    endtask : conv

    task automatic rst_chk;
        chk8(rd_data, 8'h00);
        chk1(shutdown_active, 1'b0);
        chk1(alert_oe_n, 1'b1);
        chk1(alert_out, 1'b0);
    endtask : rst_chk

    task automatic final_report;
        if (num_errors == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : final_report

    // cuts a hang short
    initial
    begin
        #1000000;
        num_errors++;
        $display("[FAIL] %0t run did not finish", $time);
        final_report();
    end

    // main sequence
    initial
    begin
        repeat (7) @(posedge ref_clk);
        #1;
        rst_chk();
        @(posedge ref_clk);
        arst_n <= 1'b1;
        foreach (rows[i])
        begin
            row = rows[i];
            if (row.w)
                host_u.write_reg(row.a, row.d);
            rd_chk(row.a, row.e);
        end
        // over setpoint, depth one, comparator mode
        conv(8'h21, 8'h05, 8'h41);
        rd_chk(8'h00, 8'h21);
        rd_chk(8'h10, 8'h05);
        rd_chk(8'h20, 8'h41);
        chk1(alert_oe_n, 1'b0);
        rd_chk(8'h01, 8'hE0);
        rd_chk(8'h01, 8'h20);
        // depth two: one matching conversion is not yet an event
        host_u.write_reg(8'h01, 8'h08);
        conv(8'h05, 8'h05, 8'h41);
        rd_chk(8'h01, 8'h28);
        conv(8'h05, 8'h05, 8'h41);
        rd_chk(8'h01, 8'hA8);
        // interrupt mode: a read of any register releases the pin
        host_u.write_reg(8'h01, 8'h02);
        conv(8'h05, 8'h31, 8'h41);
        chk1(alert_oe_n, 1'b0);
        rd_chk(8'h02, 8'h10);
        chk1(alert_oe_n, 1'b1);
        rd_chk(8'h01, 8'h62);
        // mask keeps the pin quiet but the flag still sets
        host_u.write_reg(8'h01, 8'h06);
        conv(8'h05, 8'h10, 8'h41);
        chk1(alert_oe_n, 1'b1);
        rd_chk(8'h01, 8'h66);
        host_u.write_reg(8'h01, 8'hE6);
        rd_chk(8'h01, 8'h26);
        // shutdown entry clears flags, releases pin, stops conversions
        host_u.write_reg(8'h01, 8'h02);
        conv(8'h05, 8'h31, 8'h41);
        chk1(alert_oe_n, 1'b0);
        host_u.write_reg(8'h01, 8'h03);
        #1;
        chk1(alert_oe_n, 1'b1);
        chk1(shutdown_active, 1'b1);
        rd_chk(8'h01, 8'h03);
        conv(8'h77, 8'h77, 8'h77);
        rd_chk(8'h00, 8'h05);
        // reset in mid-run
        @(posedge ref_clk);
        arst_n <= 1'b0;
        #1;
        rst_chk();
        @(posedge ref_clk);
        arst_n <= 1'b1;
        rd_chk(8'h02, 8'h4C);
        rd_chk(8'h01, 8'h00);
        // six-deep queue: five over-setpoint conversions are not enough
        host_u.write_reg(8'h01, 8'h18);
        repeat (5) conv(8'h60, 8'h00, 8'h00);
        rd_chk(8'h01, 8'h18);
        conv(8'h60, 8'h00, 8'h00);
        rd_chk(8'h01, 8'h98);
        // four-deep queue on the low side after a depth change
        host_u.write_reg(8'h01, 8'h10);
        repeat (3) conv(8'h00, 8'h00, 8'h00);
        rd_chk(8'h01, 8'h10);
        conv(8'h00, 8'h00, 8'h00);
        rd_chk(8'h01, 8'h90);
        // clock enable low: a write strobe is not taken
        @(posedge ref_clk);
        clk_en <= 1'b0;
        host_u.write_reg(8'h03, 8'h7E);
        clk_en <= 1'b1;
        rd_chk(8'h03, 8'h51);
        final_report();
    end
endmodule : three_zone_thermal_register_bank_tb
